/* File: rtl/tsa_consts.svh */
// Constants of the tag state and anticollision block: opcodes, counts, seeds.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH

// *****************************************************************
// Link character and frame
// *****************************************************************
`define TSA_CHR_BITS   4'hA      // Bits per character
`define TSA_CNT_MIN    3'h3      // Shortest request: opcode plus check
`define TSA_CNT_PARAM  3'h4      // Request with a parameter byte
`define TSA_CNT_MAX    3'h7      // Byte count saturates here
`define TSA_TX_LAST    2'h2      // Index of last answer byte

// *****************************************************************
// Opcodes
// *****************************************************************
`define TSA_OP_WAKE    8'h06     // Wake census_state
`define TSA_OP_POLL    8'h16     // Slot zero poll
`define TSA_OP_SLOT    8'h26     // Slot call
`define TSA_OP_PICK    8'h0E     // Pick by handle
`define TSA_OP_READ    8'h08     // Block read
`define TSA_OP_PROG    8'h09     // Block program
`define TSA_OP_CHECK   8'h0A     // Anti-clone check
`define TSA_OP_UID     8'h0B     // Unique id fetch
`define TSA_OP_RETIRE  8'h0F     // Retire

// *****************************************************************
// Check, random source, slot, pin positions
// *****************************************************************
`define TSA_CRC_INIT   16'hFFFF  // Check register start value
`define TSA_CRC_POLY   16'h8408  // Reflected check polynomial
`define TSA_LFSR_SEED  16'hACE1  // Random source seed, never zero
`define TSA_LFSR_TAPS  16'hB400  // Random source taps
`define TSA_SLOT_ZERO  4'h0      // Slot code answered by poll
`define TSA_PIN_FIELD  2'h0      // Field level in synchroniser
`define TSA_PIN_LCLK   2'h1      // Link clock in synchroniser
`define TSA_PIN_RXD    2'h2      // Request bit in synchroniser
`define TSA_PIN_RXF    2'h3      // Request frame in synchroniser

`endif

/* File: rtl/tsa_pkg.sv */
// Types of the tag state and anticollision block.
// Assumes the constants header is compiled in the same unit.
package tsa_pkg;

	// *****************************************************************
	// Tag states
	// *****************************************************************
	typedef enum logic [2:0] {
		ST_OFF,                      // Field too weak
		ST_READY,                    // Powered, waiting for wake
		ST_CENSUS,                   // Taking part in anticollision
		ST_SELECTED,                 // Picked, runs memory commands
		ST_PARKED,                   // Parked_state, waits for own pick
		ST_RETIRED                   // Retired until power loss
	} tsa_state_e;

	// *****************************************************************
	// Character link state
	// *****************************************************************
	typedef struct packed {
		logic       frame_d;         // Frame level, one cycle late
		logic [9:0] rx_sh;           // Receive shifter
		logic [3:0] rx_cnt;          // Received bits of character
		logic       rx_valid;        // Character done pulse
		logic       rx_bad;          // Start or stop bit wrong
		logic [7:0] rx_byte;         // Received data byte
		logic       rx_end;          // Frame end pulse
		logic [9:0] tx_sh;           // Transmit shifter
		logic [3:0] tx_cnt;          // Sent bits of character
		logic       tx_last;         // Last character of answer
		logic       tx_busy;         // Character in flight
		logic       tx_line;         // Answer bit to modulator
		logic       tx_frame;        // Answer frame active
	} tsa_link_s;

	// *****************************************************************
	// Core state
	// *****************************************************************
	typedef struct packed {
		logic [3:0]  s1;             // Pin synchroniser, first stage
		logic [3:0]  s2;             // Pin synchroniser, second stage
		logic        lclk_d;         // Link clock level, delayed
		tsa_state_e  st;             // Tag state
		logic [7:0]  handle;         // Tag handle, low nibble is slot code
		logic [15:0] lfsr;           // Random source
		logic        answered;       // Slot already used this sequence
		logic [15:0] crc;            // Running check of request
		logic [7:0]  b0;             // Opcode byte
		logic [7:0]  b1;             // Parameter byte
		logic [7:0]  p0;             // Newest byte
		logic [7:0]  p1;             // Byte before newest
		logic [2:0]  cnt;            // Bytes in frame, saturating
		logic        bad;            // Character error in frame
		logic        pend;           // Answer in progress
		logic [1:0]  idx;            // Answer byte index
		logic [15:0] chk;            // Answer check bytes
		logic        mem_go;         // Memory command pulse
		logic [7:0]  mem_op;         // Memory command opcode
		logic [7:0]  mem_arg;        // Memory command argument
	} tsa_core_s;

endpackage

/* File: rtl/tsa_chr_if.sv */
// Character channel between tag core and character link.
// Assumes both ends run on the one system clock.
interface tsa_chr_if;
	logic       bit_tick;            // Link clock rising edge pulse
	logic       rx_line;             // Synchronised request bit
	logic       rx_frame;            // Synchronised request frame level
	logic       rx_valid;            // Character received pulse
	logic       rx_bad;              // Character framing error
	logic [7:0] rx_byte;             // Received byte
	logic       rx_end;              // Request frame ended pulse
	logic       tx_valid;            // Core offers answer byte
	logic [7:0] tx_byte;             // Answer byte
	logic       tx_last;             // Byte ends the answer
	logic       tx_ready;            // Link takes the byte

	modport link (
		input  bit_tick, rx_line, rx_frame, tx_valid, tx_byte, tx_last,
		output rx_valid, rx_bad, rx_byte, rx_end, tx_ready
	);
	modport core (
		output bit_tick, rx_line, rx_frame, tx_valid, tx_byte, tx_last,
		input  rx_valid, rx_bad, rx_byte, rx_end, tx_ready
	);
endinterface

/* File: rtl/tsa_chr_link.sv */
// Ten-bit character receiver and transmitter of the tag.
// Assumes synchronised pins and a link clock edge pulse from the core.
`include "tsa_consts.svh"

module tsa_chr_link (
	input  wire logic  clock,        // System clock
	input  wire logic  nrst,         // Asynchronous reset, active low
	tsa_chr_if.link    chr,          // Character channel
	output logic       tx_line,      // Answer bit
	output logic       tx_frame      // Answer frame active
);

	// *****************************************************************
	// State
	// *****************************************************************
	tsa_pkg::tsa_link_s s;           // Registered state
	tsa_pkg::tsa_link_s n;           // Next state

	// Next state: shift in requests, shift out answers
	always_comb begin
		n = s;
		n.rx_valid = 1'b0;
		n.rx_end   = 1'b0;
		n.frame_d  = chr.rx_frame;
		// Falling frame level ends the request
		if (s.frame_d && !chr.rx_frame) begin
			n.rx_end = 1'b1;
		end
		if (!chr.rx_frame) begin
			n.rx_cnt = 4'h0;
		end else if (chr.bit_tick) begin
			// Start bit arrives first, so shift towards bit 0
			n.rx_sh  = {chr.rx_line, s.rx_sh[9:1]};
			n.rx_cnt = s.rx_cnt + 4'h1;
			if (s.rx_cnt == `TSA_CHR_BITS - 4'h1) begin
				n.rx_cnt   = 4'h0;
				n.rx_valid = 1'b1;
				n.rx_byte  = n.rx_sh[8:1];
				n.rx_bad   = n.rx_sh[0] | ~n.rx_sh[9];
			end
		end
		// Load a character: start 0, data low bit first, stop 1
		if (chr.tx_valid && !s.tx_busy) begin
			n.tx_sh    = {1'b1, chr.tx_byte, 1'b0};
			n.tx_cnt   = 4'h0;
			n.tx_busy  = 1'b1;
			n.tx_last  = chr.tx_last;
			n.tx_frame = 1'b1;
		end else if (s.tx_busy && chr.bit_tick) begin
			if (s.tx_cnt == `TSA_CHR_BITS) begin
				// Character done; frame closes after the last one
				n.tx_busy = 1'b0;
				n.tx_line = 1'b1;
				if (s.tx_last) begin
					n.tx_frame = 1'b0;
				end
			end else begin
				n.tx_line = s.tx_sh[0];
				n.tx_sh   = {1'b1, s.tx_sh[9:1]};
				n.tx_cnt  = s.tx_cnt + 4'h1;
			end
		end
	end

	// State register, line idles high
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s         <= '0;
			s.tx_line <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// *****************************************************************
	// Outputs
	// *****************************************************************
	assign chr.rx_valid = s.rx_valid;
	assign chr.rx_bad   = s.rx_bad;
	assign chr.rx_byte  = s.rx_byte;
	assign chr.rx_end   = s.rx_end;
	assign chr.tx_ready = ~s.tx_busy;
	assign tx_line      = s.tx_line;
	assign tx_frame     = s.tx_frame;

endmodule // tsa_chr_link

/* File: rtl/tsa_tag_core.sv */
// Tag command interpreter: states, random handle, slotted anticollision.
// Assumes pins from the demodulator, field detector and modulator.
`include "tsa_consts.svh"

module tsa_tag_core (
	input  wire logic        clock,      // System clock, 100 MHz
	input  wire logic        nrst,       // Asynchronous reset, active low
	input  wire logic        field_ok,   // Field strong enough, pin
	input  wire logic        link_clk,   // Recovered link clock, pin
	input  wire logic        rx_line,    // Demodulated request bit, pin
	input  wire logic        rx_frame,   // Request frame active, pin
	output logic             tx_line,    // Answer bit to modulator
	output logic             tx_frame,   // Answer frame active
	output tsa_pkg::tsa_state_e tag_state, // Current tag state
	output logic [7:0]       tag_handle, // Current tag handle
	output logic             mem_go,     // Memory command pulse
	output logic [7:0]       mem_op,     // Memory command opcode
	output logic [7:0]       mem_arg     // Memory command argument
);

	// *****************************************************************
	// Functions
	// *****************************************************************
	// One byte into the reflected check register
	function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ d[i]) begin
				r = {1'b0, r[15:1]} ^ `TSA_CRC_POLY;
			end else begin
				r = {1'b0, r[15:1]};
			end
		end
		return r;
	endfunction

	// Opcodes that carry a parameter byte
	function automatic logic needs_param(input logic [7:0] o);
		return (o == `TSA_OP_SLOT) || (o == `TSA_OP_PICK) ||
			(o == `TSA_OP_READ) || (o == `TSA_OP_PROG);
	endfunction

	// Opcodes that reach the memory side
	function automatic logic is_mem(input logic [7:0] o);
		return (o == `TSA_OP_READ) || (o == `TSA_OP_PROG) ||
			(o == `TSA_OP_CHECK) || (o == `TSA_OP_UID);
	endfunction

	// *****************************************************************
	// State and channel
	// *****************************************************************
	tsa_pkg::tsa_core_s s;           // Registered state
	tsa_pkg::tsa_core_s n;           // Next state
	tsa_chr_if          chr ();      // Character channel
	logic               field_on;    // Synchronised field level
	logic               crc_good;    // Check bytes match
	logic               frame_ok;    // Frame ended and is valid
	logic               match;       // Parameter equals own handle
	logic               start;       // Begin an answer

	assign field_on = s.s2[`TSA_PIN_FIELD];
	assign crc_good = (~s.crc == {s.p0, s.p1});
	assign match    = (s.b1 == s.handle);
	// Validity: framing, length, check, parameter present
	assign frame_ok = chr.rx_end && !s.bad && (s.cnt >= `TSA_CNT_MIN) && crc_good &&
		(!needs_param(s.b0) || (s.cnt >= `TSA_CNT_PARAM));

	// Character link
	tsa_chr_link u_link (
		.clock    (clock),
		.nrst     (nrst & field_on),   // Field loss ends a cut answer
		.chr      (chr.link),
		.tx_line  (tx_line),
		.tx_frame (tx_frame)
	);

	// Core drives its side of the channel
	assign chr.bit_tick = s.s2[`TSA_PIN_LCLK] & ~s.lclk_d;
	assign chr.rx_line  = s.s2[`TSA_PIN_RXD];
	assign chr.rx_frame = s.s2[`TSA_PIN_RXF] & field_on;
	assign chr.tx_valid = s.pend;
	assign chr.tx_last  = (s.idx == `TSA_TX_LAST);
	assign chr.tx_byte  = (s.idx == 2'h0) ? s.handle :
		(s.idx == 2'h1) ? s.chk[7:0] : s.chk[15:8];

	// *****************************************************************
	// Next state
	// *****************************************************************
	// Synchronise, collect the frame, decode per tag state
	always_comb begin
		n      = s;
		start  = 1'b0;
		n.s1   = {rx_frame, rx_line, link_clk, field_ok};
		n.s2   = s.s1;
		n.lclk_d = s.s2[`TSA_PIN_LCLK];
		n.lfsr = s.lfsr[0] ? ({1'b0, s.lfsr[15:1]} ^ `TSA_LFSR_TAPS) : {1'b0, s.lfsr[15:1]};
		n.mem_go = 1'b0;
		if (!field_on) begin
			// Field gone: only the synchroniser and random source run, nothing answers
			n.st       = tsa_pkg::ST_OFF;
			n.pend     = 1'b0;
			n.cnt      = 3'h0;
			n.bad      = 1'b0;
			n.crc      = `TSA_CRC_INIT;
			n.answered = 1'b0;
		end else if (s.st == tsa_pkg::ST_OFF) begin
			// Power-up: clean logic and a fresh handle
			n.st     = tsa_pkg::ST_READY;
			n.handle = s.lfsr[7:0];
		end else begin
			// Hand answer bytes to the link
			if (s.pend && chr.tx_ready) begin
				n.idx = s.idx + 2'h1;
				if (s.idx == `TSA_TX_LAST) begin
					n.pend = 1'b0;
				end
			end
			// Collect a character; check trails data by two bytes
			if (chr.rx_valid) begin
				n.bad = s.bad | chr.rx_bad;
				n.p0  = chr.rx_byte;
				n.p1  = s.p0;
				if (s.cnt == 3'h0) begin
					n.b0 = chr.rx_byte;
				end
				if (s.cnt == 3'h1) begin
					n.b1 = chr.rx_byte;
				end
				if (s.cnt >= 3'h2) begin
					n.crc = crc_b(s.crc, s.p1);
				end
				if (s.cnt != `TSA_CNT_MAX) begin
					n.cnt = s.cnt + 3'h1;
				end
			end
			// Frame ended: decode only valid frames
			if (chr.rx_end) begin
				n.cnt = 3'h0;
				n.bad = 1'b0;
				n.crc = `TSA_CRC_INIT;
				if (frame_ok) begin
					case (s.st)
						tsa_pkg::ST_READY: begin
							// Only wake counts here
							if (s.b0 == `TSA_OP_WAKE) begin
								n.st  = tsa_pkg::ST_CENSUS;
								start = 1'b1;
							end
						end
						tsa_pkg::ST_CENSUS: begin
							if (s.b0 == `TSA_OP_WAKE) begin
								// New handle, unslotted answer
								n.handle   = s.lfsr[7:0];
								n.answered = 1'b0;
								start      = 1'b1;
							end else if (s.b0 == `TSA_OP_POLL) begin
								// Slot zero opens a sequence
								n.handle[3:0] = s.lfsr[3:0];
								n.answered    = (s.lfsr[3:0] == `TSA_SLOT_ZERO);
								start         = (s.lfsr[3:0] == `TSA_SLOT_ZERO);
							end else if (s.b0 == `TSA_OP_SLOT) begin
								// Slot code is the handle low nibble
								if (!s.answered && (s.b1[3:0] != `TSA_SLOT_ZERO) &&
									(s.b1[3:0] == s.handle[3:0])) begin
									n.answered = 1'b1;
									start      = 1'b1;
								end
							end else if (s.b0 == `TSA_OP_PICK && match) begin
								n.st = tsa_pkg::ST_SELECTED;
							end
						end
						tsa_pkg::ST_SELECTED: begin
							// Memory work only here
							if (is_mem(s.b0)) begin
								n.mem_go  = 1'b1;
								n.mem_op  = s.b0;
								n.mem_arg = s.b1;
							end else if (s.b0 == `TSA_OP_PICK && !match) begin
								n.st = tsa_pkg::ST_PARKED;
							end else if (s.b0 == `TSA_OP_RETIRE) begin
								n.st = tsa_pkg::ST_RETIRED;
							end
						end
						tsa_pkg::ST_PARKED: begin
							if (s.b0 == `TSA_OP_PICK && match) begin
								n.st = tsa_pkg::ST_SELECTED;
							end
						end
						default: begin
							// Retired: everything ignored
						end
					endcase
				end
			end
		end
		// Answer: handle then its two check bytes
		if (start) begin
			n.pend = 1'b1;
			n.idx  = 2'h0;
			n.chk  = ~crc_b(`TSA_CRC_INIT, n.handle);
		end
	end

	// State register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s      <= '0;
			s.lfsr <= `TSA_LFSR_SEED;
			s.crc  <= `TSA_CRC_INIT;
		end else begin
			s <= n;
		end
	end

	// *****************************************************************
	// Outputs
	// *****************************************************************
	assign tag_state  = s.st;
	assign tag_handle = s.handle;
	assign mem_go     = s.mem_go;
	assign mem_op     = s.mem_op;
	assign mem_arg    = s.mem_arg;

	// *****************************************************************
	// Assertions
	// *****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	off_silent_a: assert property (
		(s.st == tsa_pkg::ST_OFF) |-> !s.pend && !s.mem_go)
		else $error("answer or memory work while powered off");

	bad_frame_a: assert property (
		(chr.rx_end && !frame_ok && field_on && s.st != tsa_pkg::ST_OFF) |=>
		s.st == $past(s.st) && s.handle == $past(s.handle) && !$rose(s.pend))
		else $error("rejected frame changed state or answered");

	ready_wake_a: assert property (
		(frame_ok && field_on && s.st == tsa_pkg::ST_READY && s.b0 == `TSA_OP_WAKE) |=>
		s.st == tsa_pkg::ST_CENSUS && s.pend && s.idx == 2'h0)
		else $error("wake in ready did not enter census with answer");

	census_pick_a: assert property (
		(frame_ok && field_on && s.st == tsa_pkg::ST_CENSUS && s.b0 == `TSA_OP_PICK) |=>
		s.st == ($past(match) ? tsa_pkg::ST_SELECTED : tsa_pkg::ST_CENSUS))
		else $error("pick in census went wrong way");

	sel_leave_a: assert property (
		(frame_ok && field_on && s.st == tsa_pkg::ST_SELECTED && s.b0 == `TSA_OP_PICK &&
		!match) |=> s.st == tsa_pkg::ST_PARKED)
		else $error("other pick did not park selected tag");

	retired_stay_a: assert property (
		(s.st == tsa_pkg::ST_RETIRED && field_on) |=>
		s.st == tsa_pkg::ST_RETIRED)
		else $error("retired tag left state with field present");

	mem_sel_a: assert property (
		s.mem_go |-> $past(s.st) == tsa_pkg::ST_SELECTED)
		else $error("memory command outside selected state");

	poll_zero_a: assert property (
		(frame_ok && field_on && s.st == tsa_pkg::ST_CENSUS && s.b0 == `TSA_OP_POLL) |=>
		s.handle[3:0] == $past(s.lfsr[3:0]) &&
		s.pend == ($past(s.lfsr[3:0]) == `TSA_SLOT_ZERO))
		else $error("poll slot draw or answer wrong");

	slot_once_a: assert property (
		(frame_ok && field_on && s.answered && s.b0 == `TSA_OP_SLOT) |=> !$rose(s.pend))
		else $error("second slot answer in one sequence");

	wake_cov: cover property (frame_ok && s.st == tsa_pkg::ST_READY && s.b0 == `TSA_OP_WAKE);
	pick_cov: cover property (s.st == tsa_pkg::ST_CENSUS ##1 s.st == tsa_pkg::ST_SELECTED);
	slot_cov: cover property (frame_ok && s.b0 == `TSA_OP_SLOT ##1 $rose(s.pend));
	retire_cov: cover property (s.st == tsa_pkg::ST_SELECTED ##1 s.st == tsa_pkg::ST_RETIRED);

endmodule // tsa_tag_core

/* File: dv/tsa_reader_model.sv */
// Reader model: sends framed request characters and collects the answer.
// Assumes the tag answers while this model runs the link clock.
`include "tsa_consts.svh"

module tsa_reader_model (
	output logic      link_clk,       // Link clock, runs only within transfers
	output logic      rx_line,        // Request bit to the tag
	output logic      rx_frame,       // Request frame level
	input  wire logic tx_line,        // Answer bit from the tag
	input  wire logic tx_frame        // Answer frame from the tag
);
	timeunit 1ns;
	timeprecision 100ps;

	// *****************************************************************
	// Answer store
	// *****************************************************************
	logic [7:0] ans [$];              // Answer bytes of last transfer
	logic       ans_bad;              // Answer character framing error

	// Idle levels, link clock stands still
	initial begin
		link_clk = 1'b0;
		rx_line  = 1'b1;
		rx_frame = 1'b0;
	end

	// One link bit period of 125 ns, bit set while clock low
	task automatic tick(input logic b);
		rx_line = b;
		#62.5 link_clk = 1'b1;
		#62.5 link_clk = 1'b0;
	endtask

	// Reflected check over bytes, sent inverted
	function automatic logic [15:0] crc16(input logic [7:0] d [$]);
		logic [15:0] c;
		c = `TSA_CRC_INIT;
		foreach (d[i]) begin
			c = c ^ {8'h00, d[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ `TSA_CRC_POLY) : (c >> 1);
		end
		return ~c;
	endfunction

	// True when the answer is exactly one byte plus its check bytes
	function automatic logic ans_is(input logic [7:0] e);
		logic [7:0]  q [$];
		logic [15:0] c;
		q = {e};
		c = crc16(q);
		return ans.size() == 3 && !ans_bad && ans[0] === e && ans[1] === c[7:0]
			&& ans[2] === c[15:8];
	endfunction

	// One exchange: request frame, then listen for the answer
	task automatic xfer(input logic [7:0] d [$], input logic bad_crc);
		logic [15:0] c;
		logic [9:0]  ch;
		logic        bits [$];
		logic [7:0]  b;
		c = crc16(d) ^ {15'h0000, bad_crc};
		d.push_back(c[7:0]);
		d.push_back(c[15:8]);
		rx_frame = 1'b1;
		foreach (d[i]) begin
			ch = {1'b1, d[i], 1'b0};
			for (int k = 0; k < 10; k++)
				tick(ch[k]);
		end
		rx_frame = 1'b0;
		for (int k = 0; k < 40; k++) begin
			tick(1'b1);
			// Idle ones between characters are skipped
			if (tx_frame === 1'b1 && (bits.size() % 10 != 0 || tx_line === 1'b0))
				bits.push_back(tx_line);
		end
		ans.delete();
		ans_bad = (bits.size() % 10) != 0;
		for (int i = 0; i + 9 < bits.size(); i += 10) begin
			ans_bad |= bits[i] !== 1'b0 || bits[i + 9] !== 1'b1;
			for (int k = 0; k < 8; k++)
				b[k] = bits[i + 1 + k];
			ans.push_back(b);
		end
	endtask
endmodule // tsa_reader_model

/* File: dv/tsa_tag_core_tb.sv */
// Testbench of the tag core: every scenario is a task that judges itself.
// Assumes the design files and the reader model are compiled before it.
`include "tsa_consts.svh"

module tsa_tag_core_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// *****************************************************************
	// Signals
	// *****************************************************************
	logic                clock;       // System clock
	logic                nrst;        // Reset, active low
	logic                field_ok;    // Field level pin
	logic                link_clk;    // Link clock from reader
	logic                rx_line;     // Request bit
	logic                rx_frame;    // Request frame level
	logic                tx_line;     // Answer bit
	logic                tx_frame;    // Answer frame
	logic                mem_go;      // Memory command pulse
	tsa_pkg::tsa_state_e tag_state;   // Tag state
	logic [7:0]          tag_handle;  // Tag handle
	logic [7:0]          mem_op;      // Memory opcode
	logic [7:0]          mem_arg;     // Memory argument
	logic [7:0]          h;           // Saved handle
	int                  bad_count;   // Mismatches
	int                  comparisons; // Comparisons made
	int                  mem_cnt;     // Memory pulses seen

	// Clock and memory pulse counter
	always #5 clock = ~clock;
	always @(negedge clock) if (mem_go === 1'b1) mem_cnt++;

	tsa_tag_core u_tsa_tag_core (.clock(clock), .nrst(nrst), .field_ok(field_ok),
		.link_clk(link_clk), .rx_line(rx_line), .rx_frame(rx_frame), .tx_line(tx_line),
		.tx_frame(tx_frame), .tag_state(tag_state), .tag_handle(tag_handle),
		.mem_go(mem_go), .mem_op(mem_op), .mem_arg(mem_arg));
	tsa_reader_model u_tsa_reader_model (.link_clk(link_clk), .rx_line(rx_line),
		.rx_frame(rx_frame), .tx_line(tx_line), .tx_frame(tx_frame));

	// *****************************************************************
	// Compare and drive helpers
	// *****************************************************************
	task automatic fail(input string m);
		bad_count++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask
	task automatic cmp_state(input tsa_pkg::tsa_state_e e);
		comparisons++;
		if (tag_state !== e) fail($sformatf("state %0d, expected %0d", tag_state, e));
	endtask
	task automatic cmp_ans(input logic on, input logic [7:0] e);
		comparisons++;
		if (on ? !u_tsa_reader_model.ans_is(e) : u_tsa_reader_model.ans.size() != 0)
			fail($sformatf("answer wrong, expected %0d with %h", on, e));
	endtask
	task automatic cmp_flag(input logic got, input string m);
		comparisons++;
		if (got !== 1'b1) fail(m);
	endtask
	task automatic cmp_mem(input int n, input logic [7:0] op, input logic [7:0] arg);
		comparisons++;
		if (mem_cnt != n || mem_op !== op || mem_arg !== arg) fail("memory command wrong");
	endtask
	// One request frame: opcode, optional parameter, good or bad check
	task automatic send(input logic [7:0] op, input logic [7:0] arg, input logic two,
		input logic bad);
		logic [7:0] d [$];
		d = {op};
		if (two) d.push_back(arg);
		@(posedge clock) #1;
		u_tsa_reader_model.xfer(d, bad);
		repeat (4) @(posedge clock);
	endtask
	task automatic field(input logic v, input tsa_pkg::tsa_state_e e);
		@(posedge clock) #1 field_ok = v;
		repeat (6) @(posedge clock);
		cmp_state(e);
	endtask

	// *****************************************************************
	// Scenarios
	// *****************************************************************
	task automatic t_power;
		send(`TSA_OP_WAKE, 8'h00, 1'b0, 1'b0);
		cmp_ans(1'b0, 8'h00);
		cmp_state(tsa_pkg::ST_OFF);
		field(1'b1, tsa_pkg::ST_READY);
		send(`TSA_OP_POLL, 8'h00, 1'b0, 1'b0);
		cmp_ans(1'b0, 8'h00);
		send(`TSA_OP_PICK, tag_handle, 1'b1, 1'b0);
		cmp_state(tsa_pkg::ST_READY);
		$display("test power done");
	endtask
	task automatic t_wake;
		h = tag_handle;
		send(`TSA_OP_WAKE, 8'h00, 1'b0, 1'b1);
		cmp_ans(1'b0, 8'h00);
		cmp_state(tsa_pkg::ST_READY);
		send(`TSA_OP_WAKE, 8'h00, 1'b0, 1'b0);
		cmp_state(tsa_pkg::ST_CENSUS);
		cmp_ans(1'b1, h);
		send(8'h55, 8'h00, 1'b1, 1'b0);
		cmp_ans(1'b0, 8'h00);
		send(`TSA_OP_WAKE, 8'h00, 1'b0, 1'b1);
		cmp_flag(tag_handle === h, "handle moved on bad frame");
		send(`TSA_OP_WAKE, 8'h00, 1'b0, 1'b0);
		cmp_state(tsa_pkg::ST_CENSUS);
		cmp_ans(1'b1, tag_handle);
		cmp_flag(tag_handle !== h, "handle not renewed");
		$display("test wake done");
	endtask
	task automatic t_anticol;
		int   hits;
		logic zero;
		hits = 0;
		zero = 1'b0;
		// Slot 0 poll repeated; on the first miss, slots swept from 1 up to the tag's own slot
		for (int p = 0; p < 12 && !zero; p++) begin
			send(`TSA_OP_POLL, 8'h00, 1'b0, 1'b0);
			zero = tag_handle[3:0] === 4'h0;
			cmp_state(tsa_pkg::ST_CENSUS);
			cmp_ans(zero, tag_handle);
			for (int s = 1; s < 16 && !zero && hits == 0; s++) begin
				send(`TSA_OP_SLOT, 8'(s), 1'b1, 1'b0);
				cmp_ans(4'(s) === tag_handle[3:0], tag_handle);
				if (4'(s) === tag_handle[3:0]) begin
					hits++;
					send(`TSA_OP_SLOT, 8'(s), 1'b1, 1'b0);
					cmp_ans(1'b0, 8'h00);
				end
			end
		end
		$display("test anticollision done");
	endtask
	task automatic t_select;
		logic [7:0] ops [4] = '{`TSA_OP_READ, `TSA_OP_PROG, `TSA_OP_CHECK, `TSA_OP_UID};
		logic [7:0] ac [3] = '{`TSA_OP_WAKE, `TSA_OP_POLL, `TSA_OP_SLOT};
		h = tag_handle;
		send(`TSA_OP_PICK, h ^ 8'h01, 1'b1, 1'b0);
		cmp_state(tsa_pkg::ST_CENSUS);
		send(`TSA_OP_READ, 8'h07, 1'b1, 1'b0);
		cmp_flag(mem_cnt == 0, "memory command before pick");
		send(`TSA_OP_PICK, h, 1'b1, 1'b0);
		cmp_state(tsa_pkg::ST_SELECTED);
		foreach (ops[i]) begin
			send(ops[i], 8'h10 + 8'(i), 1'b1, 1'b0);
			cmp_mem(i + 1, ops[i], 8'h10 + 8'(i));
		end
		foreach (ac[i]) begin
			send(ac[i], {4'h0, h[3:0]}, 1'b1, 1'b0);
			cmp_ans(1'b0, 8'h00);
			cmp_state(tsa_pkg::ST_SELECTED);
		end
		$display("test select done");
	endtask
	task automatic t_park;
		send(`TSA_OP_PICK, h ^ 8'h80, 1'b1, 1'b0);
		cmp_state(tsa_pkg::ST_PARKED);
		send(`TSA_OP_READ, 8'h07, 1'b1, 1'b0);
		send(`TSA_OP_WAKE, 8'h00, 1'b0, 1'b0);
		cmp_ans(1'b0, 8'h00);
		cmp_flag(mem_cnt == 4, "memory command while parked");
		cmp_state(tsa_pkg::ST_PARKED);
		send(`TSA_OP_PICK, h, 1'b1, 1'b0);
		cmp_state(tsa_pkg::ST_SELECTED);
		send(`TSA_OP_RETIRE, 8'h00, 1'b0, 1'b0);
		cmp_state(tsa_pkg::ST_RETIRED);
		send(`TSA_OP_PICK, h, 1'b1, 1'b0);
		send(`TSA_OP_WAKE, 8'h00, 1'b0, 1'b0);
		cmp_ans(1'b0, 8'h00);
		cmp_state(tsa_pkg::ST_RETIRED);
		field(1'b0, tsa_pkg::ST_OFF);
		field(1'b1, tsa_pkg::ST_READY);
		$display("test park and retire done");
	endtask

	// *****************************************************************
	// Run control
	// *****************************************************************
	task automatic print_verdict;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Reset for ten cycles, then the scenarios in order
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		field_ok = 1'b0;
		bad_count = 0;
		comparisons = 0;
		mem_cnt = 0;
		repeat (10) @(posedge clock);
		#1 nrst = 1'b1;
		repeat (3) @(posedge clock);
		t_power;
		t_wake;
		t_anticol;
		t_select;
		t_park;
		print_verdict;
	end

	// Watchdog, well beyond the longest expected run of about 0.5 ms
	initial begin
		#900us;
		fail("watchdog expired");
		print_verdict;
	end
endmodule // tsa_tag_core_tb
